// ==== pkg/rtc_params.svh ====
// Offsets, field positions, reset values and timing counts of the RTC
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

`define RTC_XTAL_HZ 32768
`define RTC_TICK_S 1
`define RTC_PRESCALE (`RTC_XTAL_HZ * `RTC_TICK_S)
`define RTC_SEC_MOD 60
`define RTC_MIN_MOD 60
`define RTC_HOUR_MOD 24
`define RTC_DAY_MOD 32768
`define RTC_SW_W 32

`define RTC_OFS_CTRL 8'h00
`define RTC_OFS_TIME 8'h04
`define RTC_OFS_ALARM 8'h08
`define RTC_OFS_SWATCH 8'h0c
`define RTC_OFS_IEN 8'h10
`define RTC_OFS_STAT 8'h14

`define RTC_CTRL_ALM_EN 0
`define RTC_CTRL_DALM_EN 1
`define RTC_CTRL_SW_EN 2
`define RTC_CTRL_WAKE_EN 3
`define RTC_CTRL_W 4
`define RTC_CTRL_RST 4'h0

`define RTC_EV_SEC 0
`define RTC_EV_MIN 1
`define RTC_EV_HOUR 2
`define RTC_EV_DAY 3
`define RTC_EV_ALM 4
`define RTC_EV_DALM 5
`define RTC_EV_SW 6
`define RTC_NEV 7
`define RTC_IEN_RST 7'h00

`define RTC_STAT_TIME_PEND 8
`define RTC_STAT_ALM_PEND 9
`define RTC_STAT_SW_PEND 10
`endif

// ==== pkg/rtc_pkg.sv ====
// Types shared by the RTC modules
package rtc_pkg;
	typedef struct packed {
		logic [14:0] day;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} time_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RD = 3'b010,
		ST_WR = 3'b100
	} bus_state_e;
endpackage

// ==== pkg/cnt_if.sv ====
// Carrier between the RTC core and one cascaded wrap counter
`timescale 1ns/1ns
interface cnt_if #(parameter int W = 6);
	logic inc;
	logic load;
	logic [W-1:0] load_val;
	logic [W-1:0] value;
	logic wrap;
	modport cnt(input inc, input load, input load_val,
		output value, output wrap);
	modport ctl(output inc, output load, output load_val,
		input value, input wrap);
endinterface

// ==== src/rtc_prescaler.sv ====
// Crystal edge detector and divider down to the one-second tick
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_prescaler #(
	parameter int DIV = `RTC_PRESCALE
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic xtal_i,
	output logic tick_o
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic xtal_q;
	logic [CW-1:0] cnt;
	wire rise = xtal_i & ~xtal_q;
	wire at_last = (cnt == LAST);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xtal_q <= 1'b0;
			cnt <= '0;
			tick_o <= 1'b0;
		end else begin
			xtal_q <= xtal_i;
			tick_o <= rise & at_last;
			if (rise)
				cnt <= at_last ? '0 : cnt + 1'b1;
		end
	end
endmodule

// ==== src/rtc_wrap_counter.sv ====
// One stage of the cascaded time counter, wrapping at MODULUS
`timescale 1ns/1ns
module rtc_wrap_counter #(
	parameter int W = 6,
	parameter int MODULUS = 60
) (
	input wire logic clk_i,
	input wire logic rst_i,
	cnt_if.cnt c
);
	localparam logic [W-1:0] TOP = W'(MODULUS - 1);

	// Out-of-range loads would count past TOP and carry only after wrapping through zero
	wire [W-1:0] load_fix = (c.load_val > TOP) ? '0 : c.load_val;

	assign c.wrap = c.inc & (c.value == TOP);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			c.value <= '0;
		else if (c.load)
			c.value <= load_fix;
		else if (c.inc)
			c.value <= c.wrap ? '0 : c.value + 1'b1;
	end
endmodule

// ==== src/rtc_top.sv ====
// Real-time clock with alarms, stopwatch and AHB-Lite register slave
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "rtc_params.svh"
// Function
// - Prescale the 32.768 kHz crystal to a one-second tick driving all counters.
// - Seconds and minutes wrap at 60, hours at 24, each carrying onward.
// - Day counter spans 32768 days, advancing on each hours wrap.
// - Selectable periodic events on second, minute, hour and day rollover.
// - Enabled alarm fires when the running counters equal the alarm value.
// - Time-of-day alarm repeats daily; second alarm also compares the day.
// - Stopwatch loads a programmed start and decrements once per second.
// - Enabled stopwatch raises its event when the count underflows.
// - Any enabled event also raises a wakeup request while the RTC_CTRL_WAKE_EN bit is set.
// - Wakeup request is registered on the system clock, like the counters.
// - Counting, alarms and stopwatch continue while the processor sleeps.
module rtc_top import rtc_pkg::*; #(
	parameter int PRESCALE = `RTC_PRESCALE,
	parameter int SW_W = `RTC_SW_W
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic RTC_XTAL_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	output logic IRQ_O,
	output logic WAKE_O
);
	logic tick;
	logic tick_d;
	bus_state_e state;
	bus_state_e next_state;
	logic [7:0] a_q;
	logic [`RTC_CTRL_W-1:0] ctrl;
	logic [`RTC_NEV-1:0] ien;
	logic [`RTC_NEV-1:0] stat;
	logic [`RTC_NEV-1:0] next_stat;
	logic [`RTC_NEV-1:0] ev;
	time_s time_new;
	time_s alarm_new;
	time_s alarm_q;
	time_s cur;
	logic time_pend;
	logic alm_pend;
	logic sw_pend;
	logic [SW_W-1:0] sw_new;
	logic [SW_W-1:0] sw_cnt;

	cnt_if #(.W(6)) sec_c();
	cnt_if #(.W(6)) min_c();
	cnt_if #(.W(5)) hour_c();
	cnt_if #(.W(15)) day_c();

	// Crystal is sampled as a synchronous input; the tick is one cycle
	rtc_prescaler #(.DIV(PRESCALE)) u_pre (
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.xtal_i(RTC_XTAL_I),
		.tick_o(tick)
	);

	// Cascade: each stage counts on the wrap of the stage below
	assign sec_c.inc = tick & ~time_pend;
	assign min_c.inc = sec_c.wrap;
	assign hour_c.inc = min_c.wrap;
	assign day_c.inc = hour_c.wrap;

	// A pending time write replaces the increment at the next tick
	assign sec_c.load = tick & time_pend;
	assign min_c.load = tick & time_pend;
	assign hour_c.load = tick & time_pend;
	assign day_c.load = tick & time_pend;
	assign sec_c.load_val = time_new.sec;
	assign min_c.load_val = time_new.min;
	assign hour_c.load_val = time_new.hour;
	assign day_c.load_val = time_new.day;

	rtc_wrap_counter #(.W(6), .MODULUS(`RTC_SEC_MOD)) u_sec (
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.c(sec_c)
	);
	rtc_wrap_counter #(.W(6), .MODULUS(`RTC_MIN_MOD)) u_min (
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.c(min_c)
	);
	rtc_wrap_counter #(.W(5), .MODULUS(`RTC_HOUR_MOD)) u_hour (
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.c(hour_c)
	);
	rtc_wrap_counter #(.W(15), .MODULUS(`RTC_DAY_MOD)) u_day (
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.c(day_c)
	);

	assign cur = {day_c.value, hour_c.value, min_c.value, sec_c.value};

	// Alarm compare runs one cycle after the tick, on settled counters
	wire tod_match = (cur.hour == alarm_q.hour) &&
		(cur.min == alarm_q.min) && (cur.sec == alarm_q.sec);
	wire day_match = tod_match && (cur.day == alarm_q.day);

	// Stopwatch only counts while enabled; underflow wraps to all ones
	wire sw_en = ctrl[`RTC_CTRL_SW_EN];
	wire sw_under = tick & ~sw_pend & sw_en & (sw_cnt == '0);

	assign ev[`RTC_EV_SEC] = tick;
	assign ev[`RTC_EV_MIN] = sec_c.wrap;
	assign ev[`RTC_EV_HOUR] = min_c.wrap;
	assign ev[`RTC_EV_DAY] = hour_c.wrap;
	assign ev[`RTC_EV_ALM] =
		tick_d & ctrl[`RTC_CTRL_ALM_EN] & tod_match;
	assign ev[`RTC_EV_DALM] =
		tick_d & ctrl[`RTC_CTRL_DALM_EN] & day_match;
	assign ev[`RTC_EV_SW] = sw_under;

	// Bus slave decode
	wire addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;
	wire wr_en = (state == ST_WR);
	wire wr_ctrl = wr_en & (a_q == `RTC_OFS_CTRL);
	wire wr_time = wr_en & (a_q == `RTC_OFS_TIME);
	wire wr_alarm = wr_en & (a_q == `RTC_OFS_ALARM);
	wire wr_sw = wr_en & (a_q == `RTC_OFS_SWATCH);
	wire wr_ien = wr_en & (a_q == `RTC_OFS_IEN);
	wire wr_stat = wr_en & (a_q == `RTC_OFS_STAT);

	// Write-one-to-clear; a set in the same cycle wins over the clear
	wire [`RTC_NEV-1:0] stat_clr =
		wr_stat ? HWDATA_I[`RTC_NEV-1:0] : '0;
	assign next_stat = (stat & ~stat_clr) | ev;
	wire any_evt = |(next_stat & ien);

	wire [31:0] stat_word = {21'h000000, sw_pend, alm_pend, time_pend,
		1'b0, stat};
	wire [31:0] rd_mux =
		(a_q == `RTC_OFS_CTRL) ? {28'h0000000, ctrl} :
		(a_q == `RTC_OFS_TIME) ? cur :
		(a_q == `RTC_OFS_ALARM) ? alarm_q :
		(a_q == `RTC_OFS_SWATCH) ? 32'(sw_cnt) :
		(a_q == `RTC_OFS_IEN) ? {25'h0000000, ien} :
		(a_q == `RTC_OFS_STAT) ? stat_word : 32'h00000000;

	// Reads take one wait state so a preceding CTRL, IEN or STAT write is visible
	always_comb begin
		case (state)
			ST_IDLE, ST_WR: begin
				if (addr_ok)
					next_state = HWRITE_I ? ST_WR : ST_RD;
				else
					next_state = ST_IDLE;
			end
			ST_RD: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state <= ST_IDLE;
			a_q <= 8'h00;
			HREADYOUT_O <= 1'b1;
			HRDATA_O <= 32'h00000000;
			HRESP_O <= 1'b0;
		end else begin
			state <= next_state;
			HREADYOUT_O <= (next_state != ST_RD);
			HRESP_O <= 1'b0;
			if (addr_ok)
				a_q <= HADDR_I[7:0];
			if (state == ST_RD)
				HRDATA_O <= rd_mux;
		end
	end

	// Software-written configuration
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			ctrl <= `RTC_CTRL_RST;
			ien <= `RTC_IEN_RST;
		end else begin
			if (wr_ctrl)
				ctrl <= HWDATA_I[`RTC_CTRL_W-1:0];
			if (wr_ien)
				ien <= HWDATA_I[`RTC_NEV-1:0];
		end
	end

	// Staged values wait here until the next one-second boundary
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			time_new <= '0;
			alarm_new <= '0;
			sw_new <= '0;
		end else begin
			if (wr_time)
				time_new <= time_s'(HWDATA_I);
			if (wr_alarm)
				alarm_new <= time_s'(HWDATA_I);
			if (wr_sw)
				sw_new <= HWDATA_I[SW_W-1:0];
		end
	end

	// A write in the tick cycle stays pending for the following tick
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			time_pend <= 1'b0;
			alm_pend <= 1'b0;
			sw_pend <= 1'b0;
		end else begin
			time_pend <= wr_time | (time_pend & ~tick);
			alm_pend <= wr_alarm | (alm_pend & ~tick);
			sw_pend <= wr_sw | (sw_pend & ~tick);
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I)
			alarm_q <= '0;
		else if (tick & alm_pend)
			alarm_q <= alarm_new;
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I)
			sw_cnt <= '0;
		else if (tick & sw_pend)
			sw_cnt <= sw_new;
		else if (tick & sw_en)
			sw_cnt <= sw_cnt - 1'b1;
	end

	// Timekeeping never stops for low-power states; only RST_I or missing crystal edges halt it
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			tick_d <= 1'b0;
			stat <= '0;
			IRQ_O <= 1'b0;
			WAKE_O <= 1'b0;
		end else begin
			tick_d <= tick;
			stat <= next_stat;
			IRQ_O <= any_evt;
			// Registered level, so it holds without further bus traffic
			WAKE_O <= any_evt & ctrl[`RTC_CTRL_WAKE_EN];
		end
	end
endmodule

// ==== dv/rtc_checker.sv ====
// Port-level assertions for the RTC block, bound into rtc_top
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_checker #(
	parameter int PRESCALE = `RTC_PRESCALE,
	parameter int SW_W = `RTC_SW_W
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic RTC_XTAL_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	input wire logic [31:0] HRDATA_O,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	input wire logic IRQ_O,
	input wire logic WAKE_O
);
	wire take = HSEL_I & HTRANS_I[1] & HREADY_I;
	wire rd_take = take & !HWRITE_I;
	wire wr_take = take & HWRITE_I;
	logic xtal_q;
	logic [3:0] since_x;
	// Cycles since the last crystal rise, saturating
	always_ff @(posedge CLK_SYS_I) begin
		xtal_q <= RTC_XTAL_I;
		if (RST_I)
			since_x <= 4'hf;
		else if (RTC_XTAL_I & !xtal_q)
			since_x <= 4'h0;
		else if (since_x != 4'hf)
			since_x <= since_x + 4'h1;
	end
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	okay_resp_a: assert property (HRESP_O == 1'b0)
		else $error("bus response not okay");
	read_wait_a: assert property (rd_take |=> !HREADYOUT_O ##1 HREADYOUT_O)
		else $error("read wait state wrong");
	write_fast_a: assert property (wr_take |=> HREADYOUT_O)
		else $error("write was stalled");
	wait_cause_a: assert property ($fell(HREADYOUT_O) |-> $past(rd_take))
		else $error("wait state without a read");
	rdata_hold_a: assert property ($changed(HRDATA_O) |-> !$past(HREADYOUT_O))
		else $error("read data changed outside a read");
	wake_gate_a: assert property (WAKE_O |-> IRQ_O)
		else $error("wakeup without an event");
	irq_sticky_a: assert property ($fell(IRQ_O) |->
		$past(wr_take, 2) || $past(wr_take, 3) || $past(wr_take, 4))
		else $error("interrupt dropped without a write");
	irq_on_tick_a: assert property ($rose(IRQ_O) |-> since_x < 4'h8 ||
		$past(wr_take, 2) || $past(wr_take, 3) || $past(wr_take, 4))
		else $error("interrupt rose away from a tick");
endmodule

bind rtc_top rtc_checker #(.PRESCALE(PRESCALE), .SW_W(SW_W)) chk (
	.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .RTC_XTAL_I(RTC_XTAL_I),
	.HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
	.HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
	.HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
	.HRESP_O(HRESP_O), .IRQ_O(IRQ_O), .WAKE_O(WAKE_O));

// ==== dv/tb.sv ====
// Self-checking testbench for the RTC block over AHB-Lite
`timescale 1ns/1ns
`include "rtc_params.svh"
module tb import rtc_pkg::*;;
	logic clk = 0, rst = 1, xtal = 0, xrun = 0, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 2'h0, xc = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready, hresp, irq, wake;
	int err_total = 0, checked = 0;
	rtc_top #(.PRESCALE(4), .SW_W(32)) dut (.CLK_SYS_I(clk), .RST_I(rst),
		.RTC_XTAL_I(xtal), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(hresp), .IRQ_O(irq), .WAKE_O(wake));
	always #2 clk = ~clk;
	// Crystal period of four clocks, well below half the system rate
	always @(posedge clk) begin
		if (xrun) begin
			xc <= xc + 2'h1;
			if (xc[0])
				xtal <= ~xtal;
		end
	end
	task final_report;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 20) begin
				err_total++;
				final_report;
			end
			@(posedge clk);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= 1;
		rdy;
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= 0;
		rdy;
		hsel <= 0;
		htrans <= 2'h0;
		rdy;
		d = hrdata;
	endtask
	// Poll a status flag; ticks come every sixteen clocks here
	task wstat(input int b, input logic l = 1'b1);
		logic [31:0] v;
		int n;
		n = 0;
		rd(`RTC_OFS_STAT, v);
		while (v[b] !== l) begin
			n++;
			if (n > 60) begin
				err_total++;
				final_report;
			end
			rd(`RTC_OFS_STAT, v);
		end
	endtask
	function automatic time_s tm(int d, int h, int m, int s);
		return time_s'{d[14:0], h[4:0], m[5:0], s[5:0]};
	endfunction
	task sync;
		wr(`RTC_OFS_STAT, 32'h7f);
		wstat(0);
	endtask
	task reset_vals;
		logic [31:0] v;
		for (int a = 0; a <= 24; a += 4) begin
			rd(a[7:0], v);
			cmp("reset value", 32'h0, v);
		end
	endtask
	task rollover;
		logic [31:0] v;
		wr(`RTC_OFS_IEN, 32'h0f);
		sync;
		wr(`RTC_OFS_TIME, tm(32767, 23, 59, 59));
		// Wait for the load tick itself, not for any tick after a clear
		wstat(`RTC_STAT_TIME_PEND, 1'b0);
		rd(`RTC_OFS_TIME, v);
		cmp("time load", tm(32767, 23, 59, 59), v);
		sync;
		rd(`RTC_OFS_STAT, v);
		cmp("wrap events", 32'hf, {28'h0, v[3:0]});
		rd(`RTC_OFS_TIME, v);
		cmp("full wrap", 32'h0, v);
		cmp("tick irq", 32'h1, {31'h0, irq});
		sync;
		rd(`RTC_OFS_STAT, v);
		cmp("second only", 32'h1, {28'h0, v[3:0]});
	endtask
	task alarms;
		logic [31:0] v;
		sync;
		wr(`RTC_OFS_TIME, tm(3, 1, 2, 3));
		wr(`RTC_OFS_ALARM, tm(4, 1, 2, 5));
		wr(`RTC_OFS_CTRL, 32'h3);
		wr(`RTC_OFS_IEN, 32'h30);
		wr(`RTC_OFS_STAT, 32'h7f);
		wstat(4);
		rd(`RTC_OFS_STAT, v);
		cmp("alarm kinds", 32'h1, {30'h0, v[5:4]});
		rd(`RTC_OFS_TIME, v);
		cmp("alarm time", tm(3, 1, 2, 5), v);
		wr(`RTC_OFS_CTRL, 32'h0);
	endtask
	task stopwatch;
		logic [31:0] v;
		sync;
		wr(`RTC_OFS_SWATCH, 32'h2);
		wr(`RTC_OFS_CTRL, 32'hc);
		wr(`RTC_OFS_IEN, 32'h40);
		wr(`RTC_OFS_STAT, 32'h7f);
		wstat(6);
		rd(`RTC_OFS_SWATCH, v);
		cmp("underflow", 32'hffffffff, v);
		cmp("sw irq", 32'h1, {31'h0, irq});
		cmp("wake", 32'h1, {31'h0, wake});
		wr(`RTC_OFS_CTRL, 32'h4);
		rd(`RTC_OFS_SWATCH, v);
		cmp("wake off", 32'h0, {31'h0, wake});
		cmp("irq held", 32'h1, {31'h0, irq});
		wr(`RTC_OFS_IEN, 32'h0);
		rd(`RTC_OFS_STAT, v);
		cmp("irq gated", 32'h0, {31'h0, irq});
		cmp("flag sticky", 32'h1, {31'h0, v[6]});
	endtask
	// Without crystal edges the time must not move
	task xtal_hold;
		logic [31:0] v, w;
		xrun <= 0;
		// Let a tick already in the prescaler pipeline land first
		repeat (4) @(posedge clk);
		rd(`RTC_OFS_TIME, v);
		repeat (40) @(posedge clk);
		rd(`RTC_OFS_TIME, w);
		cmp("time frozen", v, w);
		xrun <= 1;
		sync;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		reset_vals;
		xrun <= 1;
		rollover;
		alarms;
		stopwatch;
		xtal_hold;
		final_report;
	end
endmodule
